// ===== include/pfs_pkg.sv
package pfs_pkg;
	localparam int PFS_NCH = 4;
	localparam int PFS_TEMP_CODES = 3;
	localparam int PFS_VIN_CODES = 15;
	localparam logic [7:0] PFS_OFF_THRESH = 8'h09;
	localparam logic [7:0] PFS_OFF_RETRY = 8'h0A;
	localparam logic [7:0] PFS_OFF_ROUTE = 8'h0B;
	localparam logic [7:0] PFS_OFF_LATCH = 8'h0C;
	localparam logic [7:0] PFS_OFF_LIVE = 8'h0D;
	localparam logic [7:0] PFS_OFF_EVENT = 8'h0E;
	localparam logic [7:0] PFS_OFF_ALLOW = 8'h0F;
	localparam int PFS_TEMP_LSB = 4;
	localparam int PFS_TEMP_W = 2;
	localparam int PFS_VIN_LSB = 0;
	localparam int PFS_VIN_W = 4;
	localparam int PFS_SYNC_BIT = 7;
	localparam int PFS_TSD_BIT = 4;
	localparam int PFS_BTN_BIT = 6;
	localparam int PFS_HOT_BIT = 5;
	localparam int PFS_LOW_BIT = 4;
	localparam logic [1:0] PFS_TEMP_OFF = 2'h0;
	localparam logic [3:0] PFS_VIN_OFF = 4'hF;
	localparam logic [7:0] PFS_THRESH_WMASK = 8'h3F;
	localparam logic [7:0] PFS_RETRY_WMASK = 8'h8F;
	localparam logic [7:0] PFS_ROUTE_WMASK = 8'h0F;
	localparam logic [7:0] PFS_ALLOW_WMASK = 8'h7F;
	localparam logic [7:0] PFS_THRESH_RST = 8'h00;
	localparam logic [7:0] PFS_ALLOW_RST = 8'h00;
	localparam logic [7:0] PFS_FUSE_RST = 8'h00;
	localparam logic [6:0] PFS_FLAGS_RST = 7'h00;
	localparam logic [6:0] PFS_DEV_ADDR = 7'h4A;
	localparam int PFS_CLK_NS = 40;
	localparam int PFS_OK_HOLD_NS = 1000000;
	localparam int PFS_OK_HOLD_CYC = (PFS_OK_HOLD_NS + PFS_CLK_NS - 1) / PFS_CLK_NS;
	localparam int PFS_BTN_DEB_NS = 100;
	localparam int PFS_BTN_DEB_CYC = (PFS_BTN_DEB_NS + PFS_CLK_NS - 1) / PFS_CLK_NS;
	typedef enum logic [6:0] {
		PFS_ST_IDLE = 7'h01,
		PFS_ST_ADDR = 7'h02,
		PFS_ST_REG = 7'h04,
		PFS_ST_WR = 7'h08,
		PFS_ST_ACK = 7'h10,
		PFS_ST_RD = 7'h20,
		PFS_ST_MACK = 7'h40
	} pfs_i2c_st_t;
endpackage

// ===== include/pfs_filt_if.sv
`timescale 1ns/1ps
interface pfs_filt_if;
	logic raw;
	logic held;
	modport filt (input raw, output held);
	modport user (output raw, input held);
endinterface

// ===== verilog/pfs_hold_filter.sv
`timescale 1ns/1ps
module pfs_hold_filter
	import pfs_pkg::*;
#(
	parameter int HOLD = 3
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	pfs_filt_if.filt f
);
	localparam int CNT_W = $clog2(HOLD + 1);
	localparam logic [CNT_W-1:0] HOLD_M1 = CNT_W'(HOLD - 1);
	localparam logic [CNT_W-1:0] HOLD_V = CNT_W'(HOLD);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] run;

	// drop is immediate, rise waits for a full stable stretch
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt <= '0;
			f.held <= 1'b0;
		end
		else if (ce_in)
		begin
			if (!f.raw)
			begin
				cnt <= '0;
				f.held <= 1'b0;
			end
			else if (cnt == HOLD_M1)
				f.held <= 1'b1;
			else
				cnt <= cnt + 1'b1;
		end
	end

	// independent run length, only for checking
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			run <= '0;
		else if (ce_in)
			run <= !f.raw ? '0 : (run == HOLD_V) ? run : run + 1'b1;
	end

	hold_rise_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(f.held) |-> run == HOLD_V)
		else $error("filtered level rose before hold time");
endmodule

// ===== verilog/pfs_regs.sv
`timescale 1ns/1ps
module pfs_regs
	import pfs_pkg::*;
#(
	parameter int OK_HOLD_CYC = PFS_OK_HOLD_CYC,
	parameter logic [6:0] DEV_ADDR = PFS_DEV_ADDR
)
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic [PFS_TEMP_CODES-1:0] TEMP_HOT_IN,
	input wire logic [PFS_VIN_CODES-1:0] VIN_LOW_IN,
	input wire logic [PFS_NCH-1:0] CH_SUPPLY_OK_IN,
	input wire logic BUTTON_INPUT_N_IN,
	input wire logic THERMAL_TRIP_IN,
	input wire logic [PFS_NCH-1:0] CH_LATCHOFF_IN,
	input wire logic [PFS_NCH-1:0] CH_ENABLE_IN,
	input wire logic SEQ_QUIET_IN,
	input wire logic SWITCH_MODE_IN,
	input wire logic FUSE_SYNC_OUT_IN,
	input wire logic [PFS_NCH-1:0] FUSE_RETRY_DISABLE_IN,
	input wire logic [PFS_NCH-1:0] FUSE_SUPPLY_ROUTE_IN,
	output logic SUPPLY_OK_OUT,
	output logic INT_N_OUT,
	output logic INT_N_OE_OUT,
	output logic SYNC_DIR_OUT,
	output logic [PFS_NCH-1:0] RETRY_DISABLE_OUT,
	output logic [PFS_NCH-1:0] SHORT_PROT_OFF_OUT
);
	localparam int SYNC_W = PFS_TEMP_CODES + PFS_VIN_CODES + 3 * PFS_NCH + 6;
	// button, bus clock and bus data rest high; zeros here would fake a press or a bus edge
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 36'h0_0000_2003;

	logic [SYNC_W-1:0] meta;
	logic [SYNC_W-1:0] sync;
	logic [PFS_TEMP_CODES-1:0] temp_hot_s;
	logic [PFS_VIN_CODES-1:0] vin_low_s;
	logic [PFS_NCH-1:0] ch_ok_s;
	logic [PFS_NCH-1:0] ch_lo_s;
	logic [PFS_NCH-1:0] ch_en_s;
	logic btn_n_s;
	logic tsd_s;
	logic quiet_s;
	logic switch_s;
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	logic od_zero;

	pfs_i2c_st_t st;
	pfs_i2c_st_t nxt;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] ptr;
	logic nak;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_byte;

	logic fuse_pend;
	logic [7:0] thresh;
	logic [7:0] retry;
	logic [7:0] route;
	logic [7:0] allow;
	logic [4:0] latched;
	logic [6:0] event_flags;
	logic int_act;
	logic [PFS_NCH-1:0] ok_prev;
	logic btn_prev;

	logic [1:0] overheat_level;
	logic [3:0] low_supply_level;
	logic temp_hit;
	logic vin_hit;
	logic btn_rise;
	logic [PFS_NCH-1:0] fail_edge;
	logic [6:0] ev_set;
	logic [6:0] ev_clr;
	logic [4:0] lf_clr;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	pfs_filt_if ok_if ();
	pfs_filt_if btn_if ();

	// all pins except the fuse straps, and the analog comparators, cross in through two stages
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			meta <= SYNC_IDLE;
			sync <= SYNC_IDLE;
		end
		else if (CE_IN)
		begin
			meta <= {TEMP_HOT_IN, VIN_LOW_IN, CH_SUPPLY_OK_IN, BUTTON_INPUT_N_IN,
				THERMAL_TRIP_IN, CH_LATCHOFF_IN, CH_ENABLE_IN, SEQ_QUIET_IN,
				SWITCH_MODE_IN, SCL_IN, SDA_IN};
			sync <= meta;
		end
	end

	assign {temp_hot_s, vin_low_s, ch_ok_s, btn_n_s, tsd_s, ch_lo_s, ch_en_s,
		quiet_s, switch_s, scl_s, sda_s} = sync;

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			od_zero <= 1'b0;
		end
		else if (CE_IN)
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			od_zero <= 1'b0;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			PFS_OFF_THRESH: rd_mux = thresh;
			PFS_OFF_RETRY: rd_mux = retry;
			PFS_OFF_ROUTE: rd_mux = route;
			PFS_OFF_LATCH: rd_mux = {3'h0, latched};
			PFS_OFF_LIVE: rd_mux = {1'b0, btn_if.held, 2'h0, ch_ok_s};
			PFS_OFF_EVENT: rd_mux = {1'b0, event_flags};
			PFS_OFF_ALLOW: rd_mux = allow;
			default: rd_mux = 8'h00;
		endcase
	endfunction

	assign rd_byte = rd_mux(ptr);

	// serial slave: bits sampled on clock rise, data changed after fall
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			st <= PFS_ST_IDLE;
			nxt <= PFS_ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			nak <= 1'b0;
			wr_en <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			SDA_OE_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			wr_en <= 1'b0;
			if (start_det)
			begin
				st <= PFS_ST_ADDR;
				bit_cnt <= 4'h0;
				SDA_OE_OUT <= 1'b0;
			end
			else if (stop_det)
			begin
				st <= PFS_ST_IDLE;
				SDA_OE_OUT <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (st)
					PFS_ST_ADDR, PFS_ST_REG, PFS_ST_WR:
					begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					PFS_ST_MACK: nak <= sda_s;
					default: ;
				endcase
			end
			else if (scl_fall)
			begin
				case (st)
					PFS_ST_ADDR:
						if (bit_cnt == 4'h8)
						begin
							if (shift[7:1] == DEV_ADDR)
							begin
								SDA_OE_OUT <= 1'b1;
								nxt <= shift[0] ? PFS_ST_RD : PFS_ST_REG;
								st <= PFS_ST_ACK;
							end
							else
								st <= PFS_ST_IDLE;
						end
					PFS_ST_REG:
						if (bit_cnt == 4'h8)
						begin
							ptr <= shift;
							SDA_OE_OUT <= 1'b1;
							nxt <= PFS_ST_WR;
							st <= PFS_ST_ACK;
						end
					PFS_ST_WR:
						if (bit_cnt == 4'h8)
						begin
							wr_en <= 1'b1;
							wr_addr <= ptr;
							wr_data <= shift;
							ptr <= ptr + 8'h01;
							SDA_OE_OUT <= 1'b1;
							nxt <= PFS_ST_WR;
							st <= PFS_ST_ACK;
						end
					PFS_ST_ACK, PFS_ST_MACK:
						if ((st == PFS_ST_ACK && nxt == PFS_ST_RD) ||
							(st == PFS_ST_MACK && !nak))
						begin
							shift <= rd_byte;
							SDA_OE_OUT <= ~rd_byte[7];
							ptr <= ptr + 8'h01;
							bit_cnt <= 4'h1;
							st <= PFS_ST_RD;
						end
						else
						begin
							SDA_OE_OUT <= 1'b0;
							bit_cnt <= 4'h0;
							st <= (st == PFS_ST_ACK) ? nxt : PFS_ST_IDLE;
						end
					PFS_ST_RD:
						if (bit_cnt == 4'h8)
						begin
							SDA_OE_OUT <= 1'b0;
							st <= PFS_ST_MACK;
						end
						else
						begin
							shift <= {shift[6:0], 1'b0};
							SDA_OE_OUT <= ~shift[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					default: ;
				endcase
			end
		end
	end

	// fuse straps are static after power-up, so they are taken once after release
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			fuse_pend <= 1'b1;
			thresh <= PFS_THRESH_RST;
			retry <= PFS_FUSE_RST;
			route <= PFS_FUSE_RST;
			allow <= PFS_ALLOW_RST;
		end
		else if (CE_IN)
		begin
			if (fuse_pend)
			begin
				fuse_pend <= 1'b0;
				retry <= {FUSE_SYNC_OUT_IN, 3'h0, FUSE_RETRY_DISABLE_IN};
				route <= {4'h0, FUSE_SUPPLY_ROUTE_IN};
			end
			else if (wr_en)
			begin
				case (wr_addr)
					PFS_OFF_THRESH: thresh <= wr_data & PFS_THRESH_WMASK;
					PFS_OFF_RETRY: retry <= wr_data & PFS_RETRY_WMASK;
					PFS_OFF_ROUTE: route <= wr_data & PFS_ROUTE_WMASK;
					PFS_OFF_ALLOW: allow <= wr_data & PFS_ALLOW_WMASK;
					default: ;
				endcase
			end
		end
	end

	assign SYNC_DIR_OUT = retry[PFS_SYNC_BIT];
	assign RETRY_DISABLE_OUT = retry[PFS_NCH-1:0];
	assign SHORT_PROT_OFF_OUT = retry[PFS_NCH-1:0];

	assign overheat_level = thresh[PFS_TEMP_LSB +: PFS_TEMP_W];
	assign low_supply_level = thresh[PFS_VIN_LSB +: PFS_VIN_W];
	assign temp_hit = (overheat_level != PFS_TEMP_OFF) &&
		temp_hot_s[overheat_level - 2'd1];
	assign vin_hit = (low_supply_level != PFS_VIN_OFF) &&
		vin_low_s[low_supply_level];

	// supply ok: excluded channels count as good
	assign ok_if.raw = &(ch_ok_s | ~route[PFS_NCH-1:0]);
	assign SUPPLY_OK_OUT = ok_if.held;
	assign btn_if.raw = ~btn_n_s & switch_s;

	pfs_hold_filter #(.HOLD(OK_HOLD_CYC)) u_ok_hold (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.f(ok_if)
	);

	pfs_hold_filter #(.HOLD(PFS_BTN_DEB_CYC)) u_btn_deb (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.f(btn_if)
	);

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ok_prev <= '0;
			btn_prev <= 1'b0;
		end
		else if (CE_IN)
		begin
			ok_prev <= ch_ok_s;
			btn_prev <= btn_if.held;
		end
	end

	assign btn_rise = btn_if.held & ~btn_prev;
	// a channel failing is a fall of its good level while enabled and not quiet
	assign fail_edge = ok_prev & ~ch_ok_s & ch_en_s & {PFS_NCH{~quiet_s}};
	assign ev_set = {btn_rise, temp_hit, vin_hit, fail_edge};
	assign ev_clr = (wr_en && wr_addr == PFS_OFF_EVENT) ? wr_data[6:0] : '0;
	assign lf_clr = (wr_en && wr_addr == PFS_OFF_LATCH) ? wr_data[4:0] : '0;

	// set wins over a write-one clear, so a present fault cannot be cleared
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			latched <= '0;
			event_flags <= PFS_FLAGS_RST;
		end
		else if (CE_IN)
		begin
			latched <= (latched & ~lf_clr) | {tsd_s, ch_lo_s};
			if (ch_en_s == '0)
				event_flags <= PFS_FLAGS_RST;
			else
				event_flags <= (event_flags & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			int_act <= 1'b0;
		else if (CE_IN)
			int_act <= |(event_flags & allow[6:0]);
	end

	assign INT_N_OE_OUT = int_act;
	assign INT_N_OUT = od_zero;
	assign SDA_OUT = od_zero;

	overheat_set_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && temp_hit && ch_en_s != '0 |=> event_flags[PFS_HOT_BIT])
		else $error("overheat crossing did not set flag");

	overheat_off_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && overheat_level == PFS_TEMP_OFF |=> !$rose(event_flags[PFS_HOT_BIT]))
		else $error("overheat flag set while warning disabled");

	low_supply_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && low_supply_level != PFS_VIN_OFF && vin_low_s[low_supply_level]
		&& ch_en_s != '0 |=> event_flags[PFS_LOW_BIT])
		else $error("low supply crossing did not set flag");

	retry_write_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && !fuse_pend && wr_en && wr_addr == PFS_OFF_RETRY
		|=> SYNC_DIR_OUT == $past(wr_data[PFS_SYNC_BIT])
		&& SHORT_PROT_OFF_OUT == $past(wr_data[3:0]))
		else $error("retry or sync write not applied");

	supply_drop_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && (ch_ok_s & route[PFS_NCH-1:0]) != route[PFS_NCH-1:0]
		|=> !SUPPLY_OK_OUT)
		else $error("supply ok high with routed channel failing");

	thermal_hold_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && latched[PFS_TSD_BIT] && tsd_s |=> latched[PFS_TSD_BIT])
		else $error("latched flag cleared while fault present");

	thermal_set_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && $rose(tsd_s) |=> latched[PFS_TSD_BIT] [*2])
		else $error("thermal shutdown not latched");

	latchoff_set_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && ch_lo_s != '0 |=> (latched[3:0] & $past(ch_lo_s)) == $past(ch_lo_s))
		else $error("channel latch-off not latched");

	int_drive_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && (ev_set & allow[6:0]) != '0 && ch_en_s != '0 ##1 CE_IN
		|=> INT_N_OE_OUT)
		else $error("allowed event did not pull interrupt");

	int_block_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && allow == 8'h00 |=> !INT_N_OE_OUT)
		else $error("blocked event reached interrupt");

	all_off_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && ch_en_s == '0 |=> event_flags == PFS_FLAGS_RST)
		else $error("flags kept with all channels off");

	quiet_fail_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && quiet_s |=> (event_flags[3:0] & ~$past(event_flags[3:0])) == 4'h0)
		else $error("channel fail flag set while quiet");

	button_flag_a: assert property (
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && btn_rise && ch_en_s != '0 |=> event_flags[PFS_BTN_BIT])
		else $error("button press not flagged");
endmodule

// ===== bench/pfs_host_model.sv
`timescale 1ns/1ps
module pfs_host_model
	import pfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	logic nack_seen = 1'b0;
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// data only moves while the clock is low; sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		sda_out = b;
		wt(4);
		scl_out = 1'b1;
		wt(6);
		r = sda_in;
		scl_out = 1'b0;
		wt(4);
	endtask
	// also serves as repeated start, since it raises data before the clock
	task automatic start;
		sda_out = 1'b1;
		wt(4);
		scl_out = 1'b1;
		wt(6);
		sda_out = 1'b0;
		wt(6);
		scl_out = 1'b0;
		wt(4);
	endtask
	task automatic stop;
		sda_out = 1'b0;
		wt(4);
		scl_out = 1'b1;
		wt(6);
		sda_out = 1'b1;
		wt(6);
	endtask
	task automatic tx(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		if (r !== 1'b0)
			nack_seen = 1'b1;
	endtask
	// flags are cleared by writing ones to them
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		start();
		tx({PFS_DEV_ADDR, 1'b0});
		tx(off);
		tx(d);
		stop();
	endtask
	// cause of an interrupt is found by reading the event register
	task automatic rd(input logic [7:0] off, output logic [7:0] d);
		logic r;
		start();
		tx({PFS_DEV_ADDR, 1'b0});
		tx(off);
		start();
		tx({PFS_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(1'b1, r);
		stop();
	endtask
	// two bytes in one read: the host acks the first so the pointer steps on
	task automatic rd2(input logic [7:0] off, output logic [7:0] d0, output logic [7:0] d1);
		logic r;
		start();
		tx({PFS_DEV_ADDR, 1'b0});
		tx(off);
		start();
		tx({PFS_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d0[i]);
		bitx(1'b0, r);
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d1[i]);
		bitx(1'b1, r);
		stop();
	endtask
endmodule

// ===== bench/test_pmic_fault_status_regs.sv
`timescale 1ns/1ps
module test_pmic_fault_status_regs
	import pfs_pkg::*;
	;
	localparam int LIMIT = 95000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, host_sda, sda_oe, sda_unused, int_oe, int_n, sok, sync_dir;
	logic [2:0] hot = 3'h0;
	logic [14:0] low = 15'h0;
	logic [3:0] ok = 4'h0, latch = 4'h0, en = 4'hF, retry, sprot;
	logic trip = 1'b0, quiet = 1'b0, swm = 1'b0, btn_n = 1'b1, ce = 1'b1;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	// open drain with pull-up: low whenever either side pulls
	wire sda_w = host_sda & (~sda_oe | sda_unused);
	always #20 clk = ~clk;
	pfs_regs #(.OK_HOLD_CYC(20)) u_dut (
		.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_unused), .SDA_OE_OUT(sda_oe), .TEMP_HOT_IN(hot), .VIN_LOW_IN(low),
		.CH_SUPPLY_OK_IN(ok), .BUTTON_INPUT_N_IN(btn_n), .THERMAL_TRIP_IN(trip),
		.CH_LATCHOFF_IN(latch), .CH_ENABLE_IN(en), .SEQ_QUIET_IN(quiet),
		.SWITCH_MODE_IN(swm), .FUSE_SYNC_OUT_IN(1'b1), .FUSE_RETRY_DISABLE_IN(4'h5),
		.FUSE_SUPPLY_ROUTE_IN(4'h3), .SUPPLY_OK_OUT(sok), .INT_N_OUT(int_n),
		.INT_N_OE_OUT(int_oe), .SYNC_DIR_OUT(sync_dir), .RETRY_DISABLE_OUT(retry),
		.SHORT_PROT_OFF_OUT(sprot)
	);
	pfs_host_model u_host (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(host_sda));
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(off, d);
		chk(d, exp);
	endtask
	task automatic t_reset;
		rdc(PFS_OFF_THRESH, 8'h00);
		rdc(PFS_OFF_RETRY, 8'h85);
		rdc(PFS_OFF_ROUTE, 8'h03);
		rdc(PFS_OFF_LATCH, 8'h00);
		rdc(PFS_OFF_LIVE, 8'h00);
		rdc(PFS_OFF_EVENT, 8'h00);
		rdc(PFS_OFF_ALLOW, 8'h00);
		rdc(8'h20, 8'h00);
		chk({sync_dir, 3'h0, retry}, 8'h85);
		chk({4'h0, sprot}, 8'h05);
		chk({6'h0, sda_unused, int_n}, 8'h00);
	endtask
	task automatic t_config;
		u_host.wr(PFS_OFF_RETRY, 8'h7A);
		rdc(PFS_OFF_RETRY, 8'h0A);
		chk({sync_dir, 3'h0, retry}, 8'h0A);
		chk({4'h0, sprot}, 8'h0A);
		u_host.wr(PFS_OFF_THRESH, 8'hFF);
		rdc(PFS_OFF_THRESH, 8'h3F);
		u_host.wr(PFS_OFF_LIVE, 8'hFF);
		rdc(PFS_OFF_LIVE, 8'h00);
	endtask
	// condition is pulsed and removed first, so the flag must have latched
	task automatic thr_step(input logic [7:0] cfg, input logic [2:0] h, input logic [14:0] l,
		input logic [7:0] exp);
		u_host.wr(PFS_OFF_THRESH, cfg);
		hot = h;
		low = l;
		wt(8);
		hot = 3'h0;
		low = 15'h0;
		wt(8);
		rdc(PFS_OFF_EVENT, exp);
		chk({7'h0, int_oe}, 8'h00);
		u_host.wr(PFS_OFF_EVENT, 8'hFF);
	endtask
	task automatic t_thr;
		thr_step(8'h0F, 3'h7, 15'h0, 8'h00);
		for (int c = 1; c < 4; c++)
		begin
			thr_step({2'h0, c[1:0], 4'hF}, (3'h1 << (c - 1)) - 3'h1, 15'h0, 8'h00);
			thr_step({2'h0, c[1:0], 4'hF}, (3'h1 << c) - 3'h1, 15'h0, 8'h20);
		end
		for (int k = 0; k < 15; k++)
		begin
			thr_step({4'h0, k[3:0]}, 3'h7, ~((15'h2 << k) - 15'h1), 8'h00);
			thr_step({4'h0, k[3:0]}, 3'h0, ~((15'h1 << k) - 15'h1), 8'h10);
		end
		thr_step(8'h0F, 3'h0, ~15'h0, 8'h00);
	endtask
	task automatic t_irq;
		u_host.wr(PFS_OFF_ALLOW, 8'hFF);
		rdc(PFS_OFF_ALLOW, 8'h7F);
		u_host.wr(PFS_OFF_ALLOW, 8'h10);
		u_host.wr(PFS_OFF_THRESH, 8'h10);
		hot = 3'h1;
		wt(6);
		hot = 3'h0;
		wt(4);
		chk({7'h0, int_oe}, 8'h00);
		low = 15'h1;
		wt(6);
		low = 15'h0;
		wt(4);
		chk({6'h0, int_oe, int_n}, 8'h02);
		rdc(PFS_OFF_EVENT, 8'h30);
		u_host.wr(PFS_OFF_EVENT, 8'h10);
		rdc(PFS_OFF_EVENT, 8'h20);
		chk({7'h0, int_oe}, 8'h00);
		en = 4'h0;
		wt(6);
		en = 4'hF;
		rdc(PFS_OFF_EVENT, 8'h00);
		// a condition that comes and goes while the enable is low must leave no trace
		ce = 1'b0;
		low = 15'h1;
		wt(6);
		low = 15'h0;
		wt(2);
		ce = 1'b1;
		rdc(PFS_OFF_EVENT, 8'h00);
	endtask
	// routing is ch1 and ch2 from the straps; ch3 and ch4 stay low throughout
	task automatic t_supply;
		ok = 4'h3;
		wt(18);
		chk({7'h0, sok}, 8'h00);
		wt(10);
		chk({7'h0, sok}, 8'h01);
		rdc(PFS_OFF_LIVE, 8'h03);
		ok = 4'h2;
		wt(5);
		chk({7'h0, sok}, 8'h00);
		rdc(PFS_OFF_EVENT, 8'h01);
		u_host.wr(PFS_OFF_EVENT, 8'h01);
		ok = 4'h3;
		quiet = 1'b1;
		wt(6);
		ok = 4'h1;
		wt(6);
		quiet = 1'b0;
		rdc(PFS_OFF_EVENT, 8'h00);
		u_host.wr(PFS_OFF_ROUTE, 8'hF1);
		rdc(PFS_OFF_ROUTE, 8'h01);
		wt(28);
		chk({7'h0, sok}, 8'h01);
	endtask
	task automatic t_latch;
		trip = 1'b1;
		latch = 4'h2;
		wt(6);
		u_host.wr(PFS_OFF_LATCH, 8'hFF);
		rdc(PFS_OFF_LATCH, 8'h12);
		trip = 1'b0;
		latch = 4'h0;
		wt(4);
		rdc(PFS_OFF_LATCH, 8'h12);
		u_host.wr(PFS_OFF_LATCH, 8'h10);
		rdc(PFS_OFF_LATCH, 8'h02);
		u_host.wr(PFS_OFF_LATCH, 8'h02);
		rdc(PFS_OFF_LATCH, 8'h00);
	endtask
	// a single-cycle press is shorter than the debounce and must vanish
	task automatic t_button;
		logic [7:0] live_b;
		logic [7:0] ev_b;
		swm = 1'b1;
		btn_n = 1'b0;
		wt(1);
		btn_n = 1'b1;
		wt(8);
		rdc(PFS_OFF_EVENT, 8'h00);
		btn_n = 1'b0;
		wt(8);
		rdc(PFS_OFF_LIVE, 8'h41);
		btn_n = 1'b1;
		u_host.rd2(PFS_OFF_LIVE, live_b, ev_b);
		chk(live_b, 8'h01);
		chk(ev_b, 8'h40);
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			results();
		end
	end
	initial
	begin
		wt(2);
		rst_n = 1'b1;
		wt(6);
		t_reset();
		t_config();
		t_thr();
		t_irq();
		t_supply();
		t_latch();
		t_button();
		chk({7'h0, u_host.nack_seen}, 8'h00);
		results();
	end
endmodule
